// ### src/timer_two_pkg.sv
// Constants for the 16-bit capture/reload/baud-rate timer
package timer_two_pkg;
  // ----------------------------------------------------------------
  // Register addresses on the special-function bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_HOLD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_HOLD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_OVF = 7;
  localparam int BIT_EXF = 6;
  localparam int BIT_RCLK = 5;
  localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int BIT_EXEN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CT = 1;
  localparam int BIT_CPRL = 0;
  // ----------------------------------------------------------------
  // Mode register bit positions and read value of unused bits
  // ----------------------------------------------------------------
  localparam int BIT_OE = 1;
  localparam int BIT_DOWN_COUNT_ENABLE = 0;
  localparam logic [5:0] MODE_UNUSED_READ = 6'h00;
  // ----------------------------------------------------------------
  // Reset values and rates
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam int OSC_PER_MACHINE = 12;
  localparam int OSC_PER_STATE = 2;
endpackage : timer_two_pkg

// ### src/osc_divider.sv
// Divider that yields a one-cycle enable every DIVIDE clocks
`timescale 1ns/1ps
`default_nettype none
module osc_divider #(
  parameter int DIVIDE = 12
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  output logic tick_out
);
  // Cycle counter
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // Next count and tick
  always_comb begin
    if (cnt_reg == 8'(DIVIDE - 1)) begin
      cnt_next = 8'h00;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
    tick_out = (cnt_reg == 8'(DIVIDE - 1));
  end

  // Register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : osc_divider
`default_nettype wire

// ### src/timer_two.sv
// 16-bit timer/counter with capture, auto-reload and baud-rate modes
`timescale 1ns/1ps
`default_nettype none
module timer_two
  import timer_two_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic trigger_pin_in,
  input wire logic count_pin_in,
  output logic count_pin_out,
  output logic count_pin_oe_out,
  input wire logic timer1_ovf_in,
  input wire logic irq_enable_in,
  output logic irq_out,
  output logic rx_baud_tick_out,
  output logic tx_baud_tick_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic trig_s1_reg;  // First stage, read only by second
  logic trig_s2_reg;
  logic trig_s3_reg;  // Previous value for edge detect
  logic cpin_s1_reg;
  logic cpin_s2_reg;
  logic cpin_s3_reg;

  // Two flops per pin, third for edge detection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
      cpin_s1_reg <= 1'b1;
      cpin_s2_reg <= 1'b1;
      cpin_s3_reg <= 1'b1;
    end else begin
      trig_s1_reg <= trigger_pin_in;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      cpin_s1_reg <= count_pin_in;
      cpin_s2_reg <= cpin_s1_reg;
      cpin_s3_reg <= cpin_s2_reg;
    end
  end

  logic trig_fall;  // Falling edge on trigger pin
  logic cpin_fall;  // Falling edge on count pin
  assign trig_fall = trig_s3_reg & ~trig_s2_reg;
  assign cpin_fall = cpin_s3_reg & ~cpin_s2_reg;

  // ----------------------------------------------------------------
  // Rate dividers
  // ----------------------------------------------------------------
  logic machine_tick;  // One in twelve clocks
  logic state_tick;    // One in two clocks

  osc_divider #(.DIVIDE(OSC_PER_MACHINE)) u_machine_div (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tick_out(machine_tick)
  );

  osc_divider #(.DIVIDE(OSC_PER_STATE)) u_state_div (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tick_out(state_tick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;   // Control register
  logic [7:0] ctrl_next;
  logic [1:0] mode_reg;   // Output enable, down-count enable
  logic [1:0] mode_next;
  logic [15:0] cnt_reg;   // Counter
  logic [15:0] cnt_next;
  logic [15:0] hold_reg;  // Holding pair
  logic [15:0] hold_next;
  logic clk_out_reg;      // Clock-out toggle
  logic clk_out_next;

  // Decoded controls
  logic baud_mode;  // Either serial clock select set
  logic run;
  logic inc_en;     // Counting step this cycle
  logic down;       // Counting direction
  logic at_top;
  logic at_floor;
  logic roll;       // Overflow or underflow this step
  logic trig_act;   // Qualified trigger edge
  logic do_capture;
  logic do_reload;
  logic wr_ctrl;
  logic wr_mode;

  assign baud_mode = ctrl_reg[BIT_RCLK] | ctrl_reg[BIT_TRANSMIT_CLOCK_SELECT];
  assign run = ctrl_reg[BIT_RUN];
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == ADDR_CONTROL);
  assign wr_mode = sfr_wr_in && (sfr_addr_in == ADDR_MODE);

  // Count step source selection
  always_comb begin
    if (!run) begin
      inc_en = 1'b0;
    end else if (ctrl_reg[BIT_CT]) begin
      inc_en = cpin_fall;
    end else if (baud_mode) begin
      inc_en = state_tick;
    end else begin
      inc_en = machine_tick;
    end
  end

  // Direction and rollover
  assign down = mode_reg[BIT_DOWN_COUNT_ENABLE] & ~baud_mode & ~ctrl_reg[BIT_CPRL]
    & ~trig_s2_reg;
  assign at_top = (cnt_reg == COUNT_TOP);
  assign at_floor = (cnt_reg == hold_reg);
  assign roll = inc_en & (down ? at_floor : at_top);

  // Trigger action: only with external enable; capture and reload not in baud mode or with down-count enable
  assign trig_act = trig_fall & ctrl_reg[BIT_EXEN];
  assign do_capture = trig_act & ~baud_mode & ctrl_reg[BIT_CPRL]
    & ~mode_reg[BIT_DOWN_COUNT_ENABLE];
  assign do_reload = trig_act & ~baud_mode & ~ctrl_reg[BIT_CPRL]
    & ~mode_reg[BIT_DOWN_COUNT_ENABLE];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    clk_out_next = clk_out_reg;
    // Software writes
    if (wr_ctrl) begin
      ctrl_next = sfr_wdata_in;
    end
    if (wr_mode) begin
      mode_next = sfr_wdata_in[1:0];
    end
    if (sfr_wr_in && sfr_addr_in == ADDR_HOLD_LOW) begin
      hold_next[7:0] = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == ADDR_HOLD_HIGH) begin
      hold_next[15:8] = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == ADDR_COUNT_LOW) begin
      cnt_next[7:0] = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == ADDR_COUNT_HIGH) begin
      cnt_next[15:8] = sfr_wdata_in;
    end
    // Counting
    if (inc_en) begin
      if (roll) begin
        if (down) begin
          cnt_next = COUNT_TOP;
        end else if (baud_mode || !ctrl_reg[BIT_CPRL]
                     || mode_reg[BIT_DOWN_COUNT_ENABLE]) begin
          cnt_next = hold_reg;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
        clk_out_next = ~clk_out_reg;
      end else if (down) begin
        cnt_next = cnt_reg - 16'h0001;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
    // Trigger-caused reload or capture
    if (do_reload) begin
      cnt_next = hold_reg;
    end
    if (do_capture) begin
      hold_next = cnt_reg;
    end
    // Flags: hardware set wins over software clear
    if (roll && !baud_mode) begin
      ctrl_next[BIT_OVF] = 1'b1;
    end
    if (trig_act && (baud_mode || do_capture || do_reload)) begin
      ctrl_next[BIT_EXF] = 1'b1;
    end
    if (roll && mode_reg[BIT_DOWN_COUNT_ENABLE] && !baud_mode) begin
      ctrl_next[BIT_EXF] = ~ctrl_reg[BIT_EXF];
    end
  end

  // Register update
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= CONTROL_RESET;
      mode_reg <= MODE_RESET;
      cnt_reg <= COUNT_RESET;
      hold_reg <= COUNT_RESET;
      clk_out_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      clk_out_reg <= clk_out_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    case (sfr_addr_in)
      ADDR_CONTROL: sfr_rdata_out = ctrl_reg;
      ADDR_MODE: sfr_rdata_out = {MODE_UNUSED_READ, mode_reg};
      ADDR_HOLD_LOW: sfr_rdata_out = hold_reg[7:0];
      ADDR_HOLD_HIGH: sfr_rdata_out = hold_reg[15:8];
      ADDR_COUNT_LOW: sfr_rdata_out = cnt_reg[7:0];
      ADDR_COUNT_HIGH: sfr_rdata_out = cnt_reg[15:8];
      default: sfr_rdata_out = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Interrupt request from either flag; the external flag only while down-count enable is clear
  assign irq_out = irq_enable_in & (ctrl_reg[BIT_OVF]
    | (ctrl_reg[BIT_EXF] & ~mode_reg[BIT_DOWN_COUNT_ENABLE]));
  // Serial clock selection
  assign rx_baud_tick_out = ctrl_reg[BIT_RCLK] ? roll
    : timer1_ovf_in;
  assign tx_baud_tick_out = ctrl_reg[BIT_TRANSMIT_CLOCK_SELECT] ? roll
    : timer1_ovf_in;
  // Clock out on the count pin
  assign count_pin_out = clk_out_reg;
  assign count_pin_oe_out = mode_reg[BIT_OE];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ovf_baud: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (baud_mode && !wr_ctrl) |=> !$rose(ctrl_reg[BIT_OVF]))
    else $error("overflow flag set in baud mode");
  chk_ovf_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (roll && !baud_mode) |=> ctrl_reg[BIT_OVF])
    else $error("overflow flag not set");
  chk_run_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!run && !sfr_wr_in) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  chk_reload_val: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (roll && baud_mode && !sfr_wr_in) |=> cnt_reg == $past(hold_reg))
    else $error("reload value wrong");
  chk_capture_copy: assert property (@(posedge clk_sys_in)
    disable iff (rst_in)
    (do_capture && !sfr_wr_in) |=> hold_reg == $past(cnt_reg))
    else $error("capture value wrong");
  chk_exf_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    do_reload |=> ctrl_reg[BIT_EXF])
    else $error("external flag not set");
  chk_exf_noirq: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (mode_reg[BIT_DOWN_COUNT_ENABLE] && !ctrl_reg[BIT_OVF]) |-> !irq_out)
    else $error("external flag raised interrupt with down count");
  chk_timer_rate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (run && !ctrl_reg[BIT_CT] && !baud_mode && inc_en) |=> !inc_en)
    else $error("timer stepped twice in a row");
  chk_rx_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !ctrl_reg[BIT_RCLK] |-> rx_baud_tick_out == timer1_ovf_in)
    else $error("receive clock source wrong");
  chk_tx_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ctrl_reg[BIT_TRANSMIT_CLOCK_SELECT] |-> tx_baud_tick_out == roll)
    else $error("transmit clock source wrong");

  cov_overflow: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    roll && !baud_mode);
  cov_capture: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    do_capture);
  cov_baud_roll: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    roll && baud_mode);
  cov_down_roll: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    roll && down);
endmodule : timer_two
`default_nettype wire

// ### sim/pin_side_model.sv
// Far-side pin model: trigger pin, count pin and timer 1 overflow source
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
  input wire logic clk_sys_in,
  input wire logic count_pin_drive_in,
  input wire logic count_pin_oe_in,
  output logic trigger_pin_out,
  output logic count_pin_out,
  output logic timer1_ovf_out
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic ext_count_reg; // Level that the outside world drives
  initial begin
    trigger_pin_out = 1'b1;
    ext_count_reg = 1'b1;
  end
  // Pull-up on the pin; the design wins while it drives
  assign count_pin_out = count_pin_oe_in ? count_pin_drive_in : ext_count_reg;
  // One-cycle timer 1 pulse every ten clocks
  initial begin
    timer1_ovf_out = 1'b0;
    forever begin
      repeat (9) @(posedge clk_sys_in);
      timer1_ovf_out <= 1'b1;
      @(posedge clk_sys_in);
      timer1_ovf_out <= 1'b0;
    end
  end
  // Trigger level held long enough to pass the synchroniser
  task automatic set_trigger(input logic level);
    @(posedge clk_sys_in);
    trigger_pin_out <= level;
    repeat (8) @(posedge clk_sys_in);
  endtask : set_trigger
  // One low pulse on the count pin
  task automatic pulse_count();
    @(posedge clk_sys_in);
    ext_count_reg <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    ext_count_reg <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
  endtask : pulse_count
endmodule : pin_side_model
`default_nettype wire

// ### sim/timer_two_tb.sv
// Self-checking bench for the capture/reload/baud-rate timer
`timescale 1ns/1ps
`default_nettype none
module timer_two_tb;
  import timer_two_pkg::*;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  logic clk_sys_in, rst_in, sfr_wr_in, sfr_rd_in, irq_enable_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, v;
  logic trigger_pin, count_pin, pin_drv, pin_oe, t1_ovf, irq_out, rx_t, tx_t;
  int errors = 0;
  int n_tests = 0;
  int tx, rx, t1, tog;
  logic last_pin;
  row_t rows[8] = '{'{ADDR_MODE, 8'h03, 8'h03}, '{ADDR_HOLD_LOW, 8'hA5, 8'hA5},
    '{ADDR_HOLD_HIGH, 8'h5A, 8'h5A}, '{ADDR_COUNT_LOW, 8'h3C, 8'h3C},
    '{8'hC0, 8'h77, 8'h00}, '{ADDR_CONTROL, 8'h3B, 8'h3B},
    '{ADDR_MODE, 8'h00, 8'h00}, '{ADDR_CONTROL, 8'h00, 8'h00}};
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  timer_two u_timer_two (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
    .trigger_pin_in(trigger_pin), .count_pin_in(count_pin),
    .count_pin_out(pin_drv), .count_pin_oe_out(pin_oe),
    .timer1_ovf_in(t1_ovf), .irq_enable_in(irq_enable_in), .irq_out(irq_out),
    .rx_baud_tick_out(rx_t), .tx_baud_tick_out(tx_t));
  pin_side_model u_pin_side_model (.clk_sys_in(clk_sys_in),
    .count_pin_drive_in(pin_drv), .count_pin_oe_in(pin_oe),
    .trigger_pin_out(trigger_pin), .count_pin_out(count_pin),
    .timer1_ovf_out(t1_ovf));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    sfr_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(negedge clk_sys_in);
    d = sfr_rdata_out;
    @(posedge clk_sys_in);
    sfr_rd_in <= 1'b0;
  endtask : rd
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    sfr_addr_in = 8'h00;
    sfr_wdata_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    irq_enable_in = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Reset values
    rd(ADDR_CONTROL, v); check(v, CONTROL_RESET);
    rd(ADDR_COUNT_LOW, v); check(v, 8'h00);
    $display("Test reset done");
    // Register access rows
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, v); check(v, rows[i].exp);
    end
    $display("Test rows done");
    // Overflow, reload and twelve-clock stepping
    wr(ADDR_HOLD_LOW, 8'hF0); wr(ADDR_HOLD_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFF); wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h04);
    for (int k = 0; k <= 40; k++) begin
      @(negedge clk_sys_in);
      if (irq_out === 1'b1) break;
      if (k == 40) begin check(8'h01, 8'h00); tally_and_finish(); end
    end
    rd(ADDR_CONTROL, v); check(v, 8'h84);
    rd(ADDR_COUNT_LOW, v); check(v, 8'hF0);
    repeat (11) @(posedge clk_sys_in);
    rd(ADDR_COUNT_LOW, v); check(v, 8'hF1);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, v); check(v, 8'h00);
    check({7'h00, irq_out}, 8'h00);
    $display("Test overflow done");
    // Baud mode: both clocks, then transmit only
    wr(ADDR_HOLD_LOW, 8'hFE); wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF); wr(ADDR_MODE, 8'h02);
    for (int ph = 0; ph < 2; ph++) begin
      wr(ADDR_CONTROL, ph ? 8'h14 : 8'h34);
      tx = 0; rx = 0; t1 = 0; tog = 0;
      last_pin = count_pin;
      repeat (80) begin
        @(negedge clk_sys_in);
        if (tx_t === 1'b1) tx++;
        if (rx_t === 1'b1) rx++;
        if (t1_ovf === 1'b1) t1++;
        if (count_pin !== last_pin) tog++;
        last_pin = count_pin;
      end
      check(8'((tx >= 19 && tx <= 21)), 8'h01);
      check(8'(rx), 8'(ph ? t1 : tx));
      check(8'((tog > 0)), 8'h01);
      check({7'h00, pin_oe}, 8'h01);
      rd(ADDR_CONTROL, v); check(v & 8'h80, 8'h00);
    end
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_MODE, 8'h00);
    $display("Test baud done");
    // Capture on trigger, then trigger ignored without enable
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h12); wr(ADDR_CONTROL, 8'h0D);
    u_pin_side_model.set_trigger(1'b0);
    rd(ADDR_CONTROL, v); check(v, 8'h4D);
    rd(ADDR_HOLD_HIGH, v); check(v, 8'h12);
    check({7'h00, irq_out}, 8'h01);
    @(posedge clk_sys_in);
    irq_enable_in <= 1'b0;
    @(negedge clk_sys_in);
    check({7'h00, irq_out}, 8'h00);
    @(posedge clk_sys_in);
    irq_enable_in <= 1'b1;
    u_pin_side_model.set_trigger(1'b1);
    wr(ADDR_CONTROL, 8'h05); wr(ADDR_HOLD_HIGH, 8'h00);
    u_pin_side_model.set_trigger(1'b0);
    rd(ADDR_CONTROL, v); check(v, 8'h05);
    rd(ADDR_HOLD_HIGH, v); check(v, 8'h00);
    u_pin_side_model.set_trigger(1'b1);
    // Trigger-caused reload sets the external flag
    wr(ADDR_CONTROL, 8'h0C);
    u_pin_side_model.set_trigger(1'b0);
    rd(ADDR_CONTROL, v); check(v, 8'h4C);
    rd(ADDR_COUNT_HIGH, v); check(v, 8'h00);
    u_pin_side_model.set_trigger(1'b1);
    $display("Test capture done");
    // Event counting, and no counting while stopped
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00); wr(ADDR_CONTROL, 8'h06);
    repeat (3) u_pin_side_model.pulse_count();
    rd(ADDR_COUNT_LOW, v); check(v, 8'h03);
    wr(ADDR_CONTROL, 8'h02);
    u_pin_side_model.pulse_count();
    rd(ADDR_COUNT_LOW, v); check(v, 8'h03);
    $display("Test event count done");
    // Down counting with trigger low
    wr(ADDR_MODE, 8'h01); wr(ADDR_HOLD_LOW, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h05);
    u_pin_side_model.set_trigger(1'b0);
    wr(ADDR_CONTROL, 8'h04);
    repeat (40) @(posedge clk_sys_in);
    rd(ADDR_COUNT_HIGH, v); check(v, 8'h00);
    rd(ADDR_COUNT_LOW, v);
    check(8'((v === 8'h01 || v === 8'h02)), 8'h01);
    $display("Test down count done");
    // Reset in mid-run clears the registers
    u_pin_side_model.set_trigger(1'b1);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(ADDR_CONTROL, v); check(v, CONTROL_RESET);
    rd(ADDR_MODE, v); check(v, {MODE_UNUSED_READ, MODE_RESET});
    rd(ADDR_COUNT_LOW, v); check(v, 8'h00);
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule : timer_two_tb
`default_nettype wire
